// ==== core/scs_params.svh ====
// Offsets, field positions and timing constants of the channel status block
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// Register offsets (byte addresses)
`define SCS_ADDR_W 8
`define SCS_ADDR_STATUS 8'h04
`define SCS_ADDR_DATA 8'h08

// Latched bits of the status word, cleared by writing one
`define SCS_W1C_MASK 32'hC02F_FF00

// Status field positions
`define SCS_B_RX_AF_LAT 31
`define SCS_B_TX_AE_LAT 30
`define SCS_B_TC_MSB 29
`define SCS_B_TC_LSB 24
`define SCS_B_IRQ_ACT 23
`define SCS_B_PLEN_VALID 22
`define SCS_B_PURGE_ERR 21
`define SCS_B_LINK_RUN 20
`define SCS_B_RD_DMA_ERR 19
`define SCS_B_WR_DMA_ERR 18
`define SCS_B_RD_DMA_DONE 17
`define SCS_B_WR_DMA_DONE 16
`define SCS_B_TICK 15
`define SCS_B_PKT_RX 14
`define SCS_B_RX_ERR 13
`define SCS_B_OVERFLOW 12
`define SCS_B_CREDIT 11
`define SCS_B_ESCAPE 10
`define SCS_B_DISCONNECT 9
`define SCS_B_PARITY 8
`define SCS_B_RX_VALID 7
`define SCS_B_RX_FULL 6
`define SCS_B_RX_AF 5
`define SCS_B_RX_EMPTY 4
`define SCS_B_PKT_OVER 3
`define SCS_B_TX_FULL 2
`define SCS_B_TX_AE 1
`define SCS_B_TX_EMPTY 0

// Receive holding latches ahead of the host read
`define SCS_HOLD_DEPTH 4
`define SCS_HOLD_CW 3

// Timing
`define SCS_CLK_MHZ 250
`define SCS_DISC_NS 850
`define SCS_DISC_CYC ((`SCS_DISC_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_DISC_W 8
`define SCS_PURGE_US 30
`define SCS_PURGE_CYC (`SCS_PURGE_US * `SCS_CLK_MHZ)

`endif

// ==== core/scs_pkg.sv ====
// Shared types of the channel status block
`default_nettype none
package scs_pkg;

  // Purge window tracker
  typedef enum logic [0:0] {
    SCS_PURGE_IDLE = 1'b0,
    SCS_PURGE_WAIT = 1'b1
  } scs_purge_e;

  // Channel interrupt enables, held in the control register elsewhere
  typedef struct packed {
    logic master;
    logic force_irq;
    logic tx_almost_empty;
    logic rx_almost_full;
    logic rx_error;
    logic pkt_received;
    logic tick_received;
    logic packet_count_over_irq_enable;
  } scs_irq_en_s;

endpackage
`default_nettype wire

// ==== core/scs_stream_if.sv ====
// Valid/ready word stream between the block's own modules
`default_nettype none
interface scs_stream_if #(parameter int W = 32) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== core/scs_fifo.sv ====
// Synchronous word FIFO with valid/ready on both sides
`default_nettype none
module scs_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  scs_stream_if.snk wr,
  scs_stream_if.src rd,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  import scs_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] cnt;
  } scs_fifo_s;

  scs_fifo_s s;
  scs_fifo_s next_s;
  logic push;
  logic pop;

  // Full and empty come straight from the stored count
  assign wr.ready = (s.cnt != CW'(DEPTH));
  assign rd.valid = (s.cnt != '0);
  assign rd.data = s.mem[s.rptr];
  assign count = s.cnt;
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // Pointers wrap at DEPTH so odd depths also work
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wptr] = wr.data;
      next_s.wptr = (s.wptr == AW'(DEPTH-1)) ? '0 : s.wptr + 1'b1;
    end
    if (pop) begin
      next_s.rptr = (s.rptr == AW'(DEPTH-1)) ? '0 : s.rptr + 1'b1;
    end
    next_s.cnt = s.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ==== core/scs_chan_status.sv ====
// Channel status register, data port and receive/transmit word buffering
// Contract
// - Latch receive almost-full when word count exceeds its level; write one clears.
// - Latch transmit almost-empty when count drops below its level; write one clears.
// - Show last time-code in six bits; valid only when stored plus one.
// - A time-code equal to the stored one is ignored entirely.
// - Other codes are stored without tick; next plus-one code resynchronises.
// - Interrupt active shows any enabled non-DMA condition.
// - Packet-length valid while at least one length is available.
// - After link error allow 30 us purge; else latch purge error.
// - Link established exactly while link is in run state.
// - Latch read and write DMA errors separately; write one clears.
// - Latch read and write DMA list complete separately; write one clears.
// - Latch tick received and packet received; write one clears.
// - Latch receive-error summary on any of five errors.
// - Latch overflow on write into full data or length FIFO.
// - Latch credit, escape and parity errors; write one clears.
// - Latch disconnect when data and strobe stay still 850 ns.
// - Prefetch up to four words; data valid while any word held.
// - Receive full while the receive FIFO has no room.
// - Receive almost-full when count reaches level; empty from FIFO only.
// - Packet-count-over flag while length count exceeds threshold; interrupt if enabled.
// - Transmit full/empty from FIFO; almost-empty from whole-chain count.
// - Data port pushes writes, pops reads; empty repeats, full discards.
`include "scs_params.svh"
`default_nettype none
module scs_chan_status #(
  parameter int DEPTH = 16,
  parameter int LVL_W = 16,
  parameter int PURGE_CYCLES = `SCS_PURGE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`SCS_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic rx_in_valid,
  input wire logic [31:0] rx_in_data,
  output logic rx_in_ready,
  output logic tx_out_valid,
  output logic [31:0] tx_out_data,
  input wire logic tx_out_ready,
  input wire logic [LVL_W-1:0] tx_upstream_count,
  input wire logic rx_pktlen_wr_full,
  input wire logic [LVL_W-1:0] rx_pktlen_count,
  input wire logic [LVL_W-1:0] pkt_count_threshold,
  input wire logic [LVL_W-1:0] rx_almost_full_level_reg,
  input wire logic [LVL_W-1:0] tx_almost_empty_level_reg,
  input wire scs_pkg::scs_irq_en_s irq_en,
  input wire logic link_run,
  input wire logic link_error,
  input wire logic tx_pkt_open,
  input wire logic tx_purge_done,
  input wire logic tc_strobe,
  input wire logic [5:0] tc_value,
  input wire logic pkt_received,
  input wire logic credit_err,
  input wire logic escape_err,
  input wire logic parity_err,
  input wire logic data_line,
  input wire logic strobe_line,
  input wire logic rd_dma_err,
  input wire logic wr_dma_err,
  input wire logic rd_dma_done,
  input wire logic wr_dma_done
);
  import scs_pkg::*;
  localparam int CW = $clog2(DEPTH+1);
  localparam int PW = $clog2(PURGE_CYCLES+1);
  localparam int HD = `SCS_HOLD_DEPTH;
  localparam int HCW = `SCS_HOLD_CW;

  typedef struct packed {
    logic [31:0] lat;
    logic [5:0] tc;
    logic [HD-1:0][31:0] hold;
    logic [HCW-1:0] hold_cnt;
    logic [31:0] last_word;
    logic [31:0] rdata;
    scs_purge_e purge_st;
    logic [PW-1:0] purge_cnt;
    logic [`SCS_DISC_W-1:0] disc_cnt;
    logic data_q;
    logic strobe_q;
  } scs_state_s;

  scs_state_s s;
  scs_state_s next_s;

  scs_stream_if #(.W(32)) rxq_w ();
  scs_stream_if #(.W(32)) rxq_r ();
  scs_stream_if #(.W(32)) txq_w ();
  scs_stream_if #(.W(32)) txq_r ();
  logic [CW-1:0] rx_fifo_cnt;
  logic [CW-1:0] tx_fifo_cnt;

  // Receive words from the link land here ahead of the holding latches
  scs_fifo #(.W(32), .DEPTH(DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr(rxq_w),
    .rd(rxq_r),
    .count(rx_fifo_cnt)
  );

  // Host words wait here for the transmitter
  scs_fifo #(.W(32), .DEPTH(DEPTH)) u_tx_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr(txq_w),
    .rd(txq_r),
    .count(tx_fifo_cnt)
  );

  logic wr_status;
  logic rd_status;
  logic wr_data;
  logic rd_data;
  logic pop_hold;
  logic [HCW-1:0] cnt_after_pop;
  logic [LVL_W:0] rx_cnt;
  logic [LVL_W:0] tx_total;
  logic rx_af_live;
  logic tx_ae_live;
  logic pkt_over;
  logic line_activity;
  logic disc_det;
  logic purge_timeout;
  logic tick;
  logic overflow;
  logic irq_active;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic [31:0] status;

  // Register decode on the two mapped offsets; anything else reads zero
  assign wr_status = reg_wr && (reg_addr == `SCS_ADDR_STATUS);
  assign rd_status = reg_rd && (reg_addr == `SCS_ADDR_STATUS);
  assign wr_data = reg_wr && (reg_addr == `SCS_ADDR_DATA);
  assign rd_data = reg_rd && (reg_addr == `SCS_ADDR_DATA);

  assign txq_w.valid = wr_data;
  assign txq_w.data = reg_wdata;
  assign tx_out_valid = txq_r.valid;
  assign tx_out_data = txq_r.data;
  assign txq_r.ready = tx_out_ready;
  assign rxq_w.valid = rx_in_valid;
  assign rxq_w.data = rx_in_data;
  assign rx_in_ready = rxq_w.ready;

  assign pop_hold = rd_data && (s.hold_cnt != '0);
  assign cnt_after_pop = pop_hold ? s.hold_cnt - 1'b1 : s.hold_cnt;
  assign rxq_r.ready = (cnt_after_pop != HCW'(HD));

  // Word counts include the latches and, for transmit, the upstream chain
  assign rx_cnt = (LVL_W+1)'(rx_fifo_cnt) + (LVL_W+1)'(s.hold_cnt);
  assign tx_total = (LVL_W+1)'(tx_fifo_cnt) + (LVL_W+1)'(tx_upstream_count);
  assign rx_af_live = rx_cnt >= {1'b0, rx_almost_full_level_reg};
  assign tx_ae_live = tx_total < {1'b0, tx_almost_empty_level_reg};
  assign pkt_over = rx_pktlen_count > pkt_count_threshold;
  // write attempt into a full FIFO
  assign overflow = (rx_in_valid && !rxq_w.ready) || rx_pktlen_wr_full;

  // plus-one code is a valid tick
  assign tick = tc_strobe && (tc_value == s.tc + 6'h01);

  assign line_activity = (data_line != s.data_q) || (strobe_line != s.strobe_q);
  assign disc_det = link_run && !line_activity
    && (s.disc_cnt == `SCS_DISC_W'(`SCS_DISC_CYC - 1));

  // window ran out before the purge finished
  assign purge_timeout = (s.purge_st == SCS_PURGE_WAIT) && !tx_purge_done
    && (s.purge_cnt == PW'(PURGE_CYCLES - 1));

  assign irq_active = irq_en.master && (irq_en.force_irq
    || (irq_en.tx_almost_empty && tx_ae_live)
    || (irq_en.rx_almost_full && rx_af_live)
    || (irq_en.rx_error && s.lat[`SCS_B_RX_ERR])
    || (irq_en.pkt_received && s.lat[`SCS_B_PKT_RX])
    || (irq_en.tick_received && s.lat[`SCS_B_TICK])
    || (irq_en.packet_count_over_irq_enable && pkt_over));

  // Events that raise latched bits this cycle
  always_comb begin
    set_bits = '0;
    set_bits[`SCS_B_RX_AF_LAT] = rx_cnt > {1'b0, rx_almost_full_level_reg};
    set_bits[`SCS_B_TX_AE_LAT] = tx_ae_live;
    set_bits[`SCS_B_PURGE_ERR] = purge_timeout;
    set_bits[`SCS_B_RD_DMA_ERR] = rd_dma_err;
    set_bits[`SCS_B_WR_DMA_ERR] = wr_dma_err;
    set_bits[`SCS_B_RD_DMA_DONE] = rd_dma_done;
    set_bits[`SCS_B_WR_DMA_DONE] = wr_dma_done;
    set_bits[`SCS_B_TICK] = tick;
    set_bits[`SCS_B_PKT_RX] = pkt_received;
    set_bits[`SCS_B_RX_ERR] = overflow || credit_err || escape_err || disc_det || parity_err;
    set_bits[`SCS_B_OVERFLOW] = overflow;
    set_bits[`SCS_B_CREDIT] = credit_err;
    set_bits[`SCS_B_ESCAPE] = escape_err;
    set_bits[`SCS_B_DISCONNECT] = disc_det;
    set_bits[`SCS_B_PARITY] = parity_err;
  end

  // only ones on latched bits clear
  assign clr_bits = wr_status ? (reg_wdata & `SCS_W1C_MASK) : '0;

  // Status word as software sees it
  always_comb begin
    status = s.lat & `SCS_W1C_MASK;
    status[`SCS_B_TC_MSB:`SCS_B_TC_LSB] = s.tc;
    status[`SCS_B_IRQ_ACT] = irq_active;
    status[`SCS_B_PLEN_VALID] = (rx_pktlen_count != '0);
    status[`SCS_B_LINK_RUN] = link_run;
    status[`SCS_B_RX_VALID] = (s.hold_cnt != '0);
    status[`SCS_B_RX_FULL] = !rxq_w.ready;
    status[`SCS_B_RX_AF] = rx_af_live;
    status[`SCS_B_RX_EMPTY] = !rxq_r.valid;
    status[`SCS_B_PKT_OVER] = pkt_over;
    status[`SCS_B_TX_FULL] = !txq_w.ready;
    status[`SCS_B_TX_AE] = tx_ae_live;
    status[`SCS_B_TX_EMPTY] = !txq_r.valid;
  end

  // Next state of the whole block
  always_comb begin
    next_s = s;
    // Set wins over a clear in the same cycle, so no event is lost
    next_s.lat = ((s.lat & ~clr_bits) | set_bits) & `SCS_W1C_MASK;
    if (tc_strobe && (tc_value != s.tc)) begin
      next_s.tc = tc_value;
    end
    // Holding latches shift toward the read end
    if (pop_hold) begin
      for (int i = 0; i < HD - 1; i++) begin
        next_s.hold[i] = s.hold[i + 1];
      end
      next_s.last_word = s.hold[0];
    end
    next_s.hold_cnt = cnt_after_pop;
    if (rxq_r.valid && rxq_r.ready) begin
      next_s.hold[cnt_after_pop[HCW-2:0]] = rxq_r.data;
      next_s.hold_cnt = cnt_after_pop + 1'b1;
    end
    if (rd_data) begin
      next_s.rdata = (s.hold_cnt != '0) ? s.hold[0] : s.last_word;
    end else if (rd_status) begin
      next_s.rdata = status;
    end else if (reg_rd) begin
      next_s.rdata = '0;
    end
    next_s.data_q = data_line;
    next_s.strobe_q = strobe_line;
    if (!link_run || line_activity) begin
      next_s.disc_cnt = '0;
    end else if (s.disc_cnt != `SCS_DISC_W'(`SCS_DISC_CYC)) begin
      next_s.disc_cnt = s.disc_cnt + 1'b1;
    end
    case (s.purge_st)
      SCS_PURGE_IDLE: begin
        next_s.purge_cnt = '0;
        if (link_error && tx_pkt_open) begin
          next_s.purge_st = SCS_PURGE_WAIT;
        end
      end
      SCS_PURGE_WAIT: begin
        next_s.purge_cnt = s.purge_cnt + 1'b1;
        if (tx_purge_done || purge_timeout) begin
          next_s.purge_st = SCS_PURGE_IDLE;
        end
      end
      default: begin
        next_s.purge_st = SCS_PURGE_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;

  a_tick_valid: assert property (@(posedge sys_clk) disable iff (rst)
    tc_strobe && (tc_value == s.tc + 6'h01) |=> s.lat[`SCS_B_TICK] && (s.tc == $past(tc_value)))
    else $error("valid time-code did not store and tick");
  a_tc_duplicate: assert property (@(posedge sys_clk) disable iff (rst)
    tc_strobe && (tc_value == s.tc) && !wr_status |=> $stable(s.tc) && $stable(s.lat[`SCS_B_TICK]))
    else $error("duplicate time-code changed state");
  a_tc_resync: assert property (@(posedge sys_clk) disable iff (rst)
    tc_strobe && (tc_value != s.tc) && (tc_value != s.tc + 6'h01) && !s.lat[`SCS_B_TICK]
    |=> !s.lat[`SCS_B_TICK] && (s.tc == $past(tc_value)))
    else $error("out-of-sequence code mishandled");
  a_zero_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_status && (reg_wdata == '0) |=> (($past(s.lat) & ~s.lat) == '0))
    else $error("zero write cleared a latched bit");
  a_w1c_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wr_status && reg_wdata[`SCS_B_PKT_RX] && !pkt_received |=> !s.lat[`SCS_B_PKT_RX])
    else $error("packet received bit did not clear");
  a_disc_latch: assert property (@(posedge sys_clk) disable iff (rst)
    link_run && !line_activity && (s.disc_cnt == `SCS_DISC_W'(`SCS_DISC_CYC - 1))
    |=> s.lat[`SCS_B_DISCONNECT] && s.lat[`SCS_B_RX_ERR])
    else $error("disconnect not latched after idle time");
  a_purge_error: assert property (@(posedge sys_clk) disable iff (rst)
    (s.purge_st == SCS_PURGE_WAIT) && (s.purge_cnt == PW'(PURGE_CYCLES - 1)) && !tx_purge_done
    |=> s.lat[`SCS_B_PURGE_ERR] && (s.purge_st == SCS_PURGE_IDLE))
    else $error("purge window expiry not latched");
  a_hold_read: assert property (@(posedge sys_clk) disable iff (rst)
    rd_data && (s.hold_cnt != '0) |=> (reg_rdata == $past(s.hold[0])))
    else $error("data port did not return held word");
  a_empty_read: assert property (@(posedge sys_clk) disable iff (rst)
    rd_data && (s.hold_cnt == '0) |=> (reg_rdata == $past(s.last_word)))
    else $error("empty read did not repeat last word");
  a_link_bit: assert property (@(posedge sys_clk) disable iff (rst)
    rd_status |=> (reg_rdata[`SCS_B_LINK_RUN] == $past(link_run)))
    else $error("link established bit wrong");
  a_rx_af_latch: assert property (@(posedge sys_clk) disable iff (rst)
    (rx_cnt > {1'b0, rx_almost_full_level_reg}) |=> s.lat[`SCS_B_RX_AF_LAT])
    else $error("receive almost-full not latched");
  a_overflow: assert property (@(posedge sys_clk) disable iff (rst)
    rx_in_valid && !rx_in_ready |=> s.lat[`SCS_B_OVERFLOW])
    else $error("overflow not latched");
endmodule
`default_nettype wire

// ==== dv/scs_link_model.sv ====
// Link-side partner model: offers receive words, takes transmit words, drives the lines
`default_nettype none
module scs_link_model (
  input wire logic sys_clk,
  input wire logic rst,
  output logic rx_in_valid,
  output logic [31:0] rx_in_data,
  input wire logic rx_in_ready,
  input wire logic tx_out_valid,
  input wire logic [31:0] tx_out_data,
  output logic tx_out_ready,
  output logic data_line,
  output logic strobe_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rx_q[$];
  logic [31:0] tx_got[$];
  logic stall = 1'b0;
  logic active = 1'b0;
  logic use_strobe = 1'b0;
  initial begin
    rx_in_valid = 1'b0;
    rx_in_data = 32'h0000_0000;
    tx_out_ready = 1'b0;
    data_line = 1'b0;
    strobe_line = 1'b0;
  end
  // Offer holds until taken; idle data flips every cycle so stale words never look valid
  always @(posedge sys_clk) begin
    if (rx_in_valid && rx_in_ready && !rst) begin
      void'(rx_q.pop_front());
    end
    if (rx_q.size() > 0 && !rst) begin
      rx_in_valid <= 1'b1;
      rx_in_data <= rx_q[0];
    end else begin
      rx_in_valid <= 1'b0;
      rx_in_data <= ~rx_in_data;
    end
  end
  // Transmit side may stall to let the buffer fill
  always @(posedge sys_clk) begin
    if (tx_out_valid && tx_out_ready) begin
      tx_got.push_back(tx_out_data);
    end
    tx_out_ready <= !stall;
  end
  // One line toggles per cycle while active, so each line alone can keep the link alive
  always @(posedge sys_clk) begin
    if (active && use_strobe) begin
      strobe_line <= ~strobe_line;
    end else if (active) begin
      data_line <= ~data_line;
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_scs_chan_status.sv ====
// Self-checking bench for the channel status block
`include "scs_params.svh"
`default_nettype none
module tb_scs_chan_status;
  timeunit 1ns;
  timeprecision 1ps;
  import scs_pkg::*;
  logic sys_clk, rst, reg_wr, reg_rd, tx_pkt_open, link_run, link_error, tx_purge_done;
  logic tc_strobe, rx_in_valid, rx_in_ready, tx_out_valid, tx_out_ready, dl, sl;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rx_in_data, tx_out_data, d;
  logic [15:0] tx_up, plen_cnt, plen_thr, rx_lvl, tx_lvl;
  logic [5:0] tc_value;
  logic [8:0] ev;
  scs_irq_en_s irq_en;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [31:0] EV_BIT [9] = '{32'h0008_0000, 32'h0004_0000, 32'h0002_0000,
    32'h0001_0000, 32'h0000_4000, 32'h0000_2800, 32'h0000_2400, 32'h0000_2100, 32'h0000_3000};
  localparam logic [5:0] TC_V [5] = '{6'd1, 6'd1, 6'd5, 6'd6, 6'd6};
  localparam logic TC_T [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  scs_chan_status #(.PURGE_CYCLES(20)) scs_chan_status_i (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_in_valid(rx_in_valid),
    .rx_in_data(rx_in_data), .rx_in_ready(rx_in_ready), .tx_out_valid(tx_out_valid),
    .tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready), .tx_upstream_count(tx_up),
    .rx_pktlen_wr_full(ev[8]), .rx_pktlen_count(plen_cnt), .pkt_count_threshold(plen_thr),
    .rx_almost_full_level_reg(rx_lvl), .tx_almost_empty_level_reg(tx_lvl),
    .irq_en(irq_en), .link_run(link_run), .link_error(link_error),
    .tx_pkt_open(tx_pkt_open), .tx_purge_done(tx_purge_done), .tc_strobe(tc_strobe),
    .tc_value(tc_value), .pkt_received(ev[4]), .credit_err(ev[5]), .escape_err(ev[6]),
    .parity_err(ev[7]), .data_line(dl), .strobe_line(sl), .rd_dma_err(ev[0]),
    .wr_dma_err(ev[1]), .rd_dma_done(ev[2]), .wr_dma_done(ev[3]));

  scs_link_model link_i (
    .sys_clk(sys_clk), .rst(rst), .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
    .rx_in_ready(rx_in_ready), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
    .tx_out_ready(tx_out_ready), .data_line(dl), .strobe_line(sl));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Hang guard, far beyond the roughly 1200 cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is registered and stands until the next read; take it one edge later
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    v = reg_rdata;
  endtask

  task automatic st(string name, logic [31:0] mask, logic [31:0] exp);
    rd(`SCS_ADDR_STATUS, d);
    chk(name, d & mask, exp);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    {rst, reg_wr, reg_rd, tx_pkt_open, link_run, link_error, tx_purge_done, tc_strobe} = 8'h80;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    {tx_up, plen_cnt, tx_lvl} = '0;
    plen_thr = 16'h00FF;
    rx_lvl = 16'h000A;
    tc_value = 6'd0;
    ev = '0;
    irq_en = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset state, live bits untouched by writes, unmapped place
    st("reset status", 32'hFFFF_FFFF, 32'h0000_0011);
    wr(`SCS_ADDR_STATUS, 32'hFFFF_FFFF);
    wr(8'h0C, 32'hFFFF_FFFF);
    st("status after ones", 32'hFFFF_FFFF, 32'h0000_0011);
    rd(8'h0C, d);
    chk("unmapped read", d, 32'h0000_0000);
    // Latched events: set, kept by a zero write, cleared by a one
    for (int i = 0; i < 9; i++) begin
      @(posedge sys_clk);
      ev <= 9'(1 << i);
      @(posedge sys_clk);
      ev <= '0;
      st("event set", 32'h002F_FF00, EV_BIT[i]);
      wr(`SCS_ADDR_STATUS, 32'h0000_0000);
      st("event kept", 32'h002F_FF00, EV_BIT[i]);
      wr(`SCS_ADDR_STATUS, EV_BIT[i]);
      st("event cleared", 32'h002F_FF00, 32'h0000_0000);
    end
    // Time-code: valid, duplicate, out of sequence, resync, duplicate
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      tc_strobe <= 1'b1;
      tc_value <= TC_V[i];
      @(posedge sys_clk);
      tc_strobe <= 1'b0;
      st("time-code", 32'h3F00_8000, {2'b00, TC_V[i], 8'h00, TC_T[i], 15'h0000});
      wr(`SCS_ADDR_STATUS, 32'h0000_8000);
    end
    // Receive: held words with empty FIFO, then fill until refused
    for (int i = 0; i < 2; i++) link_i.rx_q.push_back(32'hA000_0000 + i);
    repeat (10) @(posedge sys_clk);
    st("rx held", 32'h0000_00B0, 32'h0000_0090);
    for (int i = 2; i < 22; i++) link_i.rx_q.push_back(32'hA000_0000 + i);
    repeat (40) @(posedge sys_clk);
    st("rx full", 32'h8000_30F0, 32'h8000_30E0);
    for (int i = 0; i < 22; i++) begin
      rd(`SCS_ADDR_DATA, d);
      chk("rx word", d, 32'hA000_0000 + i);
    end
    st("rx drained", 32'h0000_00F0, 32'h0000_0010);
    rd(`SCS_ADDR_DATA, d);
    chk("rx empty read", d, 32'hA000_0015);
    wr(`SCS_ADDR_STATUS, 32'hFFFF_FFFF);
    st("rx latches cleared", 32'h8000_3000, 32'h0000_0000);
    // Transmit: fill past full with the far side stalled, then drain
    link_i.stall <= 1'b1;
    tx_lvl <= 16'd18;
    tx_up <= 16'd2;
    for (int i = 0; i < 17; i++) wr(`SCS_ADDR_DATA, 32'hB000_0000 + i);
    st("tx full", 32'h4000_0007, 32'h4000_0004);
    link_i.stall <= 1'b0;
    for (int k = 0; k < 100 && tx_out_valid !== 1'b0; k++) @(posedge sys_clk);
    st("tx drained", 32'h4000_0007, 32'h4000_0003);
    chk("tx words", link_i.tx_got.size(), 32'd16);
    for (int i = 0; i < link_i.tx_got.size(); i++) begin
      chk("tx word", link_i.tx_got[i], 32'hB000_0000 + i);
    end
    tx_lvl <= 16'd0;
    wr(`SCS_ADDR_STATUS, 32'hFFFF_FFFF);
    // Packet-count flag, length valid and interrupt gating
    plen_cnt <= 16'd3;
    plen_thr <= 16'd2;
    irq_en.packet_count_over_irq_enable <= 1'b1;
    st("pkt over no master", 32'h00C0_0008, 32'h0040_0008);
    irq_en.master <= 1'b1;
    st("pkt over irq", 32'h00C0_0008, 32'h00C0_0008);
    plen_cnt <= 16'd2;
    st("pkt at threshold", 32'h00C0_0008, 32'h0040_0000);
    irq_en <= '0;
    plen_cnt <= 16'd0;
    // Purge window: runs out, then purged in time
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      tx_pkt_open <= 1'b1;
      link_error <= 1'b1;
      @(posedge sys_clk);
      link_error <= 1'b0;
      repeat (5) @(posedge sys_clk);
      tx_purge_done <= 1'(p);
      @(posedge sys_clk);
      tx_purge_done <= 1'b0;
      repeat (25) @(posedge sys_clk);
      st("purge error", 32'h0020_0000, p ? 32'h0 : 32'h0020_0000);
      wr(`SCS_ADDR_STATUS, 32'h0020_0000);
    end
    tx_pkt_open <= 1'b0;
    // Disconnect: active lines keep it off, still lines raise it
    link_i.active <= 1'b1;
    link_run <= 1'b1;
    repeat (230) @(posedge sys_clk);
    st("lines active", 32'h0010_2200, 32'h0010_0000);
    link_i.use_strobe <= 1'b1;
    repeat (230) @(posedge sys_clk);
    st("strobe active", 32'h0010_2200, 32'h0010_0000);
    link_i.active <= 1'b0;
    repeat (250) @(posedge sys_clk);
    st("lines still", 32'h0010_2200, 32'h0010_2200);
    link_run <= 1'b0;
    wr(`SCS_ADDR_STATUS, 32'hFFFF_FFFF);
    st("final", 32'hFFFF_FFFF, 32'h0600_0011);
    wrap_up();
  end
endmodule
`default_nettype wire
